// ==== logic/irq_pkg.sv ====
// irq_pkg: constants and carrier types of the twelve vector interrupt unit.
// assumes one 20 MHz system clock and a machine cycle of twelve clocks.
`default_nettype none
package irq_pkg;

	// ----------------------------------------------------------------
	// sizes and timing
	// ----------------------------------------------------------------
	localparam int NUM_VECTORS = 12;
	localparam int NUM_PAIRS = 6;
	localparam int NUM_SHARED = 4;
	localparam int CLK_PERIOD_NS = 50;
	localparam int MC_CLOCKS = 12; // clocks per machine cycle
	localparam logic [3:0] MC_LAST = 4'(MC_CLOCKS - 1);

	// ----------------------------------------------------------------
	// vector indices, in fixed polling order
	// ----------------------------------------------------------------
	localparam int VEC_EXT0 = 0;
	localparam int VEC_TIMER0 = 1;
	localparam int VEC_EXT1 = 2;
	localparam int VEC_TIMER1 = 3;
	localparam int VEC_SERIAL = 4;
	localparam int VEC_TIMER2 = 5;
	localparam int VEC_ADC = 6;
	localparam int VEC_EXT2 = 7;

	// vector addresses by index
	localparam logic [15:0] VECTOR_ADDR [NUM_VECTORS] = '{
		16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
		16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B};

	// ----------------------------------------------------------------
	// pin sampler bit positions
	// ----------------------------------------------------------------
	localparam int PIN_EXT0 = 0;
	localparam int PIN_EXT1 = 1;
	localparam int PIN_EXT2 = 2;
	localparam int PIN_SHARED_LSB = 3;
	localparam int PIN_RELOAD = 7;
	localparam int PIN_COUNT = 8;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_OFFER = 1'b1
	} state_t;

	typedef struct packed {
		logic global_enable;
		logic [NUM_VECTORS-1:0] enable_vector;
		logic [1:0] pin01_edge_sel; // 1: falling edge, 0: low level
		logic [1:0] pin23_rise_sel; // 1: rising edge, 0: falling edge
		logic [NUM_PAIRS-1:0] priority_select_low;
		logic [NUM_PAIRS-1:0] priority_select_high;
	} irq_config_t;

	typedef struct packed {
		logic timer0_overflow_flag;
		logic timer1_overflow_flag;
		logic serial_receive_done_flag;
		logic serial_transmit_done_flag;
		logic timer2_overflow_flag;
		logic conversion_done_flag;
	} periph_flags_t;

endpackage
`default_nettype wire

// ==== logic/pin_sampler.sv ====
// pin_sampler: two-flop synchroniser plus edge detect for a group of pins.
// assumes pins are asynchronous to clk and idle high.
`timescale 1ns/1ps
`default_nettype none

module pin_sampler #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
		logic [WIDTH-1:0] prev;
	} sampler_t;

	sampler_t s_reg;
	sampler_t s_next;

	// ----------------------------------------------------------------
	// state update; stage1 feeds stage2 only
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.stage1 = pin_in;
		s_next.stage2 = s_reg.stage1;
		s_next.prev = s_reg.stage2;
	end

	// reset to high so idle pins give no spurious edge
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	// edges from settled samples only
	assign level = s_reg.stage2;
	assign rise = s_reg.stage2 & ~s_reg.prev;
	assign fall = ~s_reg.stage2 & s_reg.prev;

endmodule // pin_sampler
`default_nettype wire

// ==== logic/irq_unit.sv ====
// irq_unit: twelve vector interrupt unit with four priority levels.
// assumes a cpu sequencer that takes an offered vector and reports returns,
// and peripheral flags that are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module irq_unit (
	input wire logic clk,
	input wire logic rst,
	input wire irq_pkg::irq_config_t cfg,
	input wire irq_pkg::periph_flags_t periph,
	input wire logic ext_request_pin_zero,
	input wire logic ext_request_pin_one,
	input wire logic ext_request_pin_two,
	input wire logic timer2_reload_trigger_pin,
	input wire logic [3:0] shared_pin_in,
	output logic [3:0] shared_pin_out,
	output logic [3:0] shared_pin_oe,
	input wire logic [3:0] compare_drive_en,
	input wire logic [3:0] compare_drive_value,
	input wire logic [3:0] compare_match,
	output logic [3:0] capture_event,
	output logic timer0_gate,
	output logic timer1_gate,
	output logic timer2_reload_strobe,
	input wire logic timer2_flag_clear,
	output logic [6:0] ext_pin_request_flags,
	output logic timer2_external_reload_flag,
	output logic vector_request,
	output logic [15:0] vector_address,
	output logic [1:0] vector_level,
	input wire logic vector_taken,
	input wire logic return_done,
	output logic [11:0] ack_strobe,
	output logic [3:0] in_service_levels
);

	typedef struct packed {
		irq_pkg::state_t state;
		logic [3:0] tick_cnt;
		logic [6:0] ext_flags;
		logic ext_reload_flag;
		logic [3:0] in_service;
		logic [3:0] vec_id;
		logic [1:0] vec_level;
		logic [15:0] vec_addr;
		logic [11:0] ack;
		logic [3:0] capture;
		logic [3:0] pin_out;
		logic [3:0] pin_oe;
		logic reload;
	} ctrl_t;

	ctrl_t c_reg;
	ctrl_t c_next;

	logic [7:0] pin_level;
	logic [7:0] pin_rise;
	logic [7:0] pin_fall;
	logic tick;
	logic [11:0] raw_req;
	logic [11:0] active;
	logic best_found;
	logic [1:0] best_lvl;
	logic [3:0] best_id;
	logic svc_found;
	logic [1:0] svc_lvl;
	logic accept;

	// ----------------------------------------------------------------
	// pin sampling
	// ----------------------------------------------------------------
	// ext 2 has its own pin; 3..6 sit on the compare/capture pins
	pin_sampler #(
		.WIDTH(irq_pkg::PIN_COUNT)
	) u_pins (
		.clk(clk),
		.rst(rst),
		.pin_in({timer2_reload_trigger_pin, shared_pin_in, ext_request_pin_two,
			ext_request_pin_one, ext_request_pin_zero}),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// ----------------------------------------------------------------
	// request collection and priority pick
	// ----------------------------------------------------------------
	always_comb begin
		tick = (c_reg.tick_cnt == irq_pkg::MC_LAST);
		raw_req = {c_reg.ext_flags[6:2],
			periph.conversion_done_flag,
			periph.timer2_overflow_flag | c_reg.ext_reload_flag,
			periph.serial_receive_done_flag | periph.serial_transmit_done_flag,
			periph.timer1_overflow_flag,
			c_reg.ext_flags[1],
			periph.timer0_overflow_flag,
			c_reg.ext_flags[0]};
		active = raw_req & cfg.enable_vector & {12{cfg.global_enable}};
		best_found = 1'b0;
		best_lvl = 2'h0;
		best_id = 4'h0;
		// strict compare keeps the lowest index on a tie
		for (int i = 0; i < irq_pkg::NUM_VECTORS; i++) begin
			if (active[i] && (!best_found ||
				{cfg.priority_select_high[i % irq_pkg::NUM_PAIRS],
				cfg.priority_select_low[i % irq_pkg::NUM_PAIRS]} > best_lvl)) begin
				best_found = 1'b1;
				best_lvl = {cfg.priority_select_high[i % irq_pkg::NUM_PAIRS],
					cfg.priority_select_low[i % irq_pkg::NUM_PAIRS]};
				best_id = 4'(i);
			end
		end
		svc_found = 1'b0;
		svc_lvl = 2'h0;
		for (int j = 0; j < 4; j++) begin
			if (c_reg.in_service[j]) begin
				svc_found = 1'b1;
				svc_lvl = 2'(j);
			end
		end
		accept = best_found && (!svc_found || best_lvl > svc_lvl);
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		c_next = c_reg;
		c_next.tick_cnt = tick ? 4'h0 : c_reg.tick_cnt + 4'h1;
		c_next.ack = 12'h000;
		c_next.capture = pin_rise[6:3] | pin_fall[6:3];
		c_next.pin_out = compare_drive_value;
		c_next.pin_oe = compare_drive_en;
		c_next.reload = pin_fall[irq_pkg::PIN_RELOAD];

		// return ends the innermost level first
		if (return_done && svc_found) begin
			c_next.in_service[svc_lvl] = 1'b0;
		end

		case (c_reg.state)
			irq_pkg::ST_IDLE: begin
				// polled once per machine cycle, offered on the next edge
				if (tick && accept) begin
					c_next.state = irq_pkg::ST_OFFER;
					c_next.vec_id = best_id;
					c_next.vec_level = best_lvl;
					c_next.vec_addr = irq_pkg::VECTOR_ADDR[best_id];
				end
			end
			irq_pkg::ST_OFFER: begin
				if (vector_taken) begin
					c_next.state = irq_pkg::ST_IDLE;
					c_next.in_service[c_reg.vec_level] = 1'b1;
					c_next.ack[c_reg.vec_id] = 1'b1;
				end else if (tick && !active[c_reg.vec_id]) begin
					c_next.state = irq_pkg::ST_IDLE;
				end
			end
			default: begin
				c_next.state = irq_pkg::ST_IDLE;
			end
		endcase

		// ext 0/1: level mode follows the pin, edge mode latches a fall
		for (int k = 0; k < 2; k++) begin
			if (!cfg.pin01_edge_sel[k]) begin
				c_next.ext_flags[k] = ~pin_level[k];
			end else if (pin_fall[k]) begin
				c_next.ext_flags[k] = 1'b1;
			end else if (c_next.ack[k * 2]) begin
				c_next.ext_flags[k] = 1'b0;
			end
		end

		// ext 2..6 are cleared on vectoring; a new edge wins the clear
		for (int m = 2; m < 7; m++) begin
			if (c_next.ack[m + 5]) begin
				c_next.ext_flags[m] = 1'b0;
			end
		end
		if (cfg.pin23_rise_sel[0] ? pin_rise[irq_pkg::PIN_EXT2] : pin_fall[irq_pkg::PIN_EXT2]) begin
			c_next.ext_flags[2] = 1'b1;
		end
		if (compare_match[0] ||
			(cfg.pin23_rise_sel[1] ? pin_rise[irq_pkg::PIN_SHARED_LSB] : pin_fall[irq_pkg::PIN_SHARED_LSB])) begin
			c_next.ext_flags[3] = 1'b1;
		end
		for (int n = 1; n < irq_pkg::NUM_SHARED; n++) begin
			if (compare_match[n] || pin_rise[irq_pkg::PIN_SHARED_LSB + n]) begin
				c_next.ext_flags[3 + n] = 1'b1;
			end
		end

		// software clears the reload flag; a fall in the same cycle wins
		if (pin_fall[irq_pkg::PIN_RELOAD]) begin
			c_next.ext_reload_flag = 1'b1;
		end else if (timer2_flag_clear) begin
			c_next.ext_reload_flag = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			c_reg <= '0;
		end else begin
			c_reg <= c_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign vector_request = (c_reg.state == irq_pkg::ST_OFFER);
	assign vector_address = c_reg.vec_addr;
	assign vector_level = c_reg.vec_level;
	assign ack_strobe = c_reg.ack;
	assign in_service_levels = c_reg.in_service;
	assign ext_pin_request_flags = c_reg.ext_flags;
	assign timer2_external_reload_flag = c_reg.ext_reload_flag;
	assign timer2_reload_strobe = c_reg.reload;
	assign capture_event = c_reg.capture;
	assign shared_pin_out = c_reg.pin_out;
	assign shared_pin_oe = c_reg.pin_oe;
	assign timer0_gate = pin_level[irq_pkg::PIN_EXT0];
	assign timer1_gate = pin_level[irq_pkg::PIN_EXT1];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// cycles an acceptable request has waited while idle
	logic [4:0] wait_cnt;
	always_ff @(posedge clk) begin
		if (rst || c_reg.state != irq_pkg::ST_IDLE || !accept) begin
			wait_cnt <= 5'h00;
		end else begin
			wait_cnt <= wait_cnt + 5'h01;
		end
	end

	sequence fall0_seq;
		cfg.pin01_edge_sel[0] && pin_fall[irq_pkg::PIN_EXT0];
	endsequence

	sequence rise2_seq;
		cfg.pin23_rise_sel[0] && $rose(pin_level[irq_pkg::PIN_EXT2]);
	endsequence

	vector_addr_map_a: assert property (vector_request |-> vector_address == ((c_reg.vec_id < 4'h6) ?
		16'h0003 + {9'h000, c_reg.vec_id, 3'h0} : 16'h0013 + {9'h000, c_reg.vec_id, 3'h0}))
		else $error("vector address does not match vector");
	disabled_withdraw_a: assert property (
		vector_request && !vector_taken && !cfg.enable_vector[c_reg.vec_id] |-> ##[1:12] !vector_request)
		else $error("disabled vector still offered");
	response_bound_a: assert property (wait_cnt <= 5'(irq_pkg::MC_CLOCKS))
		else $error("pending request not offered within a machine cycle");
	edge0_latch_a: assert property (fall0_seq |=> ext_pin_request_flags[0])
		else $error("falling edge on pin 0 not latched");
	rise2_latch_a: assert property (rise2_seq |=> ext_pin_request_flags[2])
		else $error("rising edge on pin 2 not latched");
	reload_flag_a: assert property ($fell(pin_level[irq_pkg::PIN_RELOAD]) |=>
		timer2_external_reload_flag && timer2_reload_strobe)
		else $error("reload pin fall missed");
	compare_flag_a: assert property (compare_match[0] |=> ext_pin_request_flags[3])
		else $error("compare match did not set request");
	preempt_level_a: assert property (vector_request |->
		(c_reg.in_service >> c_reg.vec_level) == 4'h0)
		else $error("vector offered at or below level in service");

endmodule // irq_unit
`default_nettype wire

// ==== verif/cpu_model.sv ====
// cpu_model: behavioural sequencer that takes offered vectors and returns.
// assumes the unit's offer handshake on clk; delays come from the bench.
`timescale 1ns/1ps
`default_nettype none

module cpu_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic vector_request,
	input wire logic [7:0] take_delay,
	input wire logic [7:0] ret_delay,
	output logic vector_taken,
	output logic return_done
);
	logic [7:0] wait_cnt;
	logic [7:0] ret_cnt;
	logic [3:0] depth;

	// ----------------------------------------------------------------
	// take and return
	// ----------------------------------------------------------------
	// taken only while offered, one cycle; innermost service returns first
	always_ff @(posedge clk) begin
		vector_taken <= 1'b0;
		return_done <= 1'b0;
		if (rst) begin
			wait_cnt <= 8'h00;
			ret_cnt <= 8'h00;
			depth <= 4'h0;
		end else begin
			if (!vector_request) begin
				wait_cnt <= 8'h00; // a withdrawn offer restarts the wait
			end else if (!vector_taken) begin
				if (wait_cnt >= take_delay) begin
					vector_taken <= 1'b1;
					wait_cnt <= 8'h00;
				end else begin
					wait_cnt <= wait_cnt + 8'h01;
				end
			end
			if (vector_taken) begin
				depth <= depth + 4'h1;
				ret_cnt <= 8'h00;
			end else if (depth != 4'h0) begin
				if (ret_cnt >= ret_delay) begin
					return_done <= 1'b1;
					depth <= depth - 4'h1;
					ret_cnt <= 8'h00;
				end else begin
					ret_cnt <= ret_cnt + 8'h01;
				end
			end
		end
	end
endmodule // cpu_model

`default_nettype wire

// ==== verif/twelve_vector_interrupt_unit_tb_top.sv ====
// testbench of irq_unit: random and corner scenarios, self-checking.
// assumes cpu_model as sequencer; flags and pins are driven here.
`timescale 1ns/1ps
`default_nettype none

module twelve_vector_interrupt_unit_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	irq_pkg::irq_config_t cfg = '0;
	irq_pkg::periph_flags_t periph = '0;
	logic [6:0] pins = 7'h7F;
	logic reload_pin = 1'b1;
	logic [3:0] cmp_en = 4'h0;
	logic [3:0] cmp_val = 4'h0;
	logic [3:0] cmp_match = 4'h0;
	logic t2_clr = 1'b0;
	logic [7:0] take_d = 8'h00;
	logic [7:0] ret_d = 8'h08;
	logic [3:0] shared_out, shared_oe, capture;
	logic timer0_gate, timer1_gate, t2_strobe, t2_flag, vector_request, taken, ret_done;
	logic [6:0] ext_flags;
	logic [15:0] vector_address;
	logic [1:0] vector_level;
	logic [11:0] ack_strobe;
	logic [3:0] in_service_levels;
	integer seed = 32'hF8C0A3E4;
	int num_errors = 0;
	int checked = 0;
	int n, a, b, f;
	int src [5] = '{1, 3, 4, 5, 6};
	logic [3:0] cap_seen;

	initial begin
		forever #25 clk = ~clk;
	end

	irq_unit irq_unit_i (.clk(clk), .rst(rst), .cfg(cfg), .periph(periph),
		.ext_request_pin_zero(pins[0]), .ext_request_pin_one(pins[1]), .ext_request_pin_two(pins[2]),
		.timer2_reload_trigger_pin(reload_pin), .shared_pin_in(pins[6:3]), .shared_pin_out(shared_out),
		.shared_pin_oe(shared_oe), .compare_drive_en(cmp_en), .compare_drive_value(cmp_val),
		.compare_match(cmp_match), .capture_event(capture), .timer0_gate(timer0_gate),
		.timer1_gate(timer1_gate), .timer2_reload_strobe(t2_strobe), .timer2_flag_clear(t2_clr),
		.ext_pin_request_flags(ext_flags), .timer2_external_reload_flag(t2_flag),
		.vector_request(vector_request), .vector_address(vector_address), .vector_level(vector_level),
		.vector_taken(taken), .return_done(ret_done), .ack_strobe(ack_strobe),
		.in_service_levels(in_service_levels));

	cpu_model cpu_model_i (.clk(clk), .rst(rst), .vector_request(vector_request), .take_delay(take_d),
		.ret_delay(ret_d), .vector_taken(taken), .return_done(ret_done));

	// ----------------------------------------------------------------
	// expectations and checks
	// ----------------------------------------------------------------
	function automatic logic [15:0] addr_of(int i);
		return (i < 6) ? 16'(3 + 8 * i) : 16'(67 + 8 * (i - 6));
	endfunction

	function automatic logic [1:0] lvl_of(int i);
		return {cfg.priority_select_high[i % 6], cfg.priority_select_low[i % 6]};
	endfunction

	// active pin level: pins 0,1 low; 2,3 by select; 4..6 rising
	function automatic logic act_of(int i);
		return (i == 0 || i == 2) ? 1'b0 : (i == 7) ? cfg.pin23_rise_sel[0] :
			(i == 8) ? cfg.pin23_rise_sel[1] : 1'b1;
	endfunction

	// pin and ext flag index of a pin-driven vector
	function automatic int pin_of(int i);
		return (i == 0) ? 0 : (i == 2) ? 1 : (i == 7) ? 2 : i - 5;
	endfunction

	function automatic logic is_pin(int i);
		return (i == 0 || i == 2 || i >= 7);
	endfunction

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask

	task automatic results();
		if (num_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// one cycle of a bounded wait; running out ends the run
	task automatic tick(inout int cnt, input int lim);
		@(negedge clk);
		cnt++;
		if (cnt > lim) begin
			num_errors++;
			results();
		end
	endtask

	// raise or drop the source of vector i; caller is at a falling edge
	task automatic fire(input int i, input logic on);
		case (i)
			1: periph.timer0_overflow_flag = on;
			3: periph.timer1_overflow_flag = on;
			4: begin
				periph.serial_receive_done_flag = on & seed[0];
				periph.serial_transmit_done_flag = on & !seed[0];
			end
			5: periph.timer2_overflow_flag = on;
			6: periph.conversion_done_flag = on;
			default: pins[pin_of(i)] = on ? act_of(i) : !act_of(i);
		endcase
		if (i == 5 && !on) begin
			t2_clr = 1'b1; // owner clears the reload flag too
			@(negedge clk);
			t2_clr = 1'b0;
		end
	endtask

	// wait for the offer of vector i, check it, then drop its source
	task automatic serve(input int i, input int lim);
		int c;
		logic [1:0] lv;
		c = 0;
		lv = lvl_of(i);
		while (vector_request !== 1'b1) tick(c, lim);
		chk("vector_address", addr_of(i), vector_address);
		chk("vector_level", 16'(lv), 16'(vector_level));
		if (i == 0) chk("timer0_gate", 16'h0000, 16'(timer0_gate));
		if (i == 2) chk("timer1_gate", 16'h0000, 16'(timer1_gate));
		c = 0;
		while (ack_strobe === 12'h000) tick(c, 20);
		chk("ack_strobe", 16'(12'h001 << i), 16'(ack_strobe));
		chk("in_service", 16'h0001, 16'(in_service_levels[lv]));
		@(negedge clk);
		fire(i, 1'b0);
	endtask

	task automatic wait_idle();
		int c;
		c = 0;
		while (in_service_levels !== 4'h0 || vector_request !== 1'b0) tick(c, 400);
	endtask

	task automatic rand_cfg();
		cfg.global_enable = 1'b1;
		cfg.pin01_edge_sel = 2'($random(seed));
		cfg.pin23_rise_sel = 2'($random(seed));
		cfg.priority_select_low = 6'($random(seed));
		cfg.priority_select_high = 6'($random(seed));
		take_d = 8'($random(seed)) & 8'h03;
		ret_d = 8'h08 + (8'($random(seed)) & 8'h0F); // leaves time for a level pin to release
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk("vector_request", 16'h0000, 16'(vector_request));
		chk("timer0_gate", 16'h0001, 16'(timer0_gate));
		// every vector masked first, then enabled, under random modes
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 12; i++) begin
				rand_cfg();
				cfg.enable_vector = ~(12'h001 << i);
				fire(i, 1'b0);
				repeat (6) @(negedge clk);
				fire(i, 1'b1);
				cap_seen = 4'h0;
				repeat (30) begin
					@(negedge clk);
					cap_seen = cap_seen | capture;
					chk("masked_request", 16'h0000, 16'(vector_request));
				end
				// only the shared pin just toggled may report a capture edge
				chk("capture_event", (i >= 8) ? (16'h0001 << (i - 8)) : 16'h0000, 16'(cap_seen));
				chk("ext_pin_request_flags", is_pin(i) ? (16'h0001 << pin_of(i)) : 16'h0000, 16'(ext_flags));
				cfg.enable_vector[i] = 1'b1;
				serve(i, 14);
				wait_idle();
			end
		end
		// two requests at once: level first, then polling order
		for (int t = 0; t < 16; t++) begin
			rand_cfg();
			n = $unsigned($random(seed)) % 5;
			a = src[n];
			b = src[(n + 1 + $unsigned($random(seed)) % 4) % 5];
			cfg.enable_vector = (12'h001 << a) | (12'h001 << b);
			fire(a, 1'b1);
			fire(b, 1'b1);
			f = (lvl_of(a) > lvl_of(b) || (lvl_of(a) == lvl_of(b) && a < b)) ? a : b;
			serve(f, 14);
			serve(a + b - f, 80);
			wait_idle();
		end
		// higher level preempts a lower one in service
		rand_cfg();
		cfg.priority_select_low[1] = 1'b0;
		cfg.priority_select_high[1] = 1'b0;
		cfg.priority_select_low[3] = 1'b1;
		cfg.priority_select_high[3] = 1'b1;
		cfg.enable_vector = 12'h00A;
		ret_d = 8'h64;
		fire(1, 1'b1);
		serve(1, 14);
		fire(3, 1'b1);
		serve(3, 14);
		chk("in_service_nested", 16'h0009, 16'(in_service_levels));
		wait_idle();
		// an offer masked again before it is taken is withdrawn untaken
		rand_cfg();
		cfg.enable_vector = 12'h040;
		take_d = 8'hFF; // sequencer too slow to take it first
		fire(6, 1'b1);
		n = 0;
		while (vector_request !== 1'b1) tick(n, 14);
		cfg.enable_vector = 12'h000;
		n = 0;
		while (vector_request !== 1'b0) tick(n, 13);
		chk("withdrawn_in_service", 16'h0000, 16'(in_service_levels));
		fire(6, 1'b0);
		// reload pin fall sets the timer 2 external flag
		rand_cfg();
		cfg.enable_vector = 12'h020;
		reload_pin = 1'b0;
		n = 0;
		while (t2_strobe !== 1'b1) tick(n, 10);
		@(negedge clk);
		chk("t2_flag", 16'h0001, 16'(t2_flag));
		reload_pin = 1'b1;
		serve(5, 14);
		wait_idle();
		chk("t2_flag", 16'h0000, 16'(t2_flag));
		// compare matches raise requests 3..6; compare outputs reach the pins
		for (int c = 0; c < 4; c++) begin
			rand_cfg();
			cfg.enable_vector = 12'h100 << c;
			cmp_en = 4'($random(seed));
			cmp_val = 4'($random(seed));
			cmp_match = 4'h1 << c;
			@(negedge clk);
			cmp_match = 4'h0;
			@(negedge clk);
			chk("shared_pin_out", 16'(cmp_val), 16'(shared_out));
			chk("shared_pin_oe", 16'(cmp_en), 16'(shared_oe));
			serve(8 + c, 14);
			wait_idle();
		end
		results();
	end

	initial begin
		repeat (90000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule // twelve_vector_interrupt_unit_tb_top

`default_nettype wire
